// ### common/sfp_defs.vh
// shared constants of the 9-bit fifo with programmable almost flags
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH
`define SFP_DATA_W 9
`define SFP_OFF_W 8
`define SFP_DEPTH_DEFAULT 64
`define SFP_STAGE_DEPTH 8
`define SFP_OFF_DEFAULT_LO 8'h07
`define SFP_OFF_DEFAULT_HI 8'h00
`define SFP_SEL_EMPTY_LO 2'h0
`define SFP_SEL_EMPTY_HI 2'h1
`define SFP_SEL_FULL_LO 2'h2
`define SFP_SEL_FULL_HI 2'h3
`define SFP_SEL_RESET 2'h0
`define SFP_PINS_W 16
`define SFP_PIN_WCLK 15
`define SFP_PIN_RCLK 14
`define SFP_PIN_WEN_A 13
`define SFP_PIN_WEN_B 12
`define SFP_PIN_REN_A 11
`define SFP_PIN_REN_B 10
`define SFP_PIN_OE 9
`define SFP_PIN_DATA_HI 8
`define SFP_PIN_DATA_LO 0
`define SFP_PIN_IDLE 16'h3e00
`define SFP_OUT_RESET 9'h000
`define SFP_FLAG_HIGH 1'b1
`define SFP_FLAG_LOW 1'b0
`endif

// ### rtl/sfp_ram.v
// storage array of the fifo, one port, registered read data
`timescale 1ns/1ns
`include "sfp_defs.vh"

module sfp_ram #(
  parameter WIDTH = `SFP_DATA_W,
  parameter DEPTH = `SFP_DEPTH_DEFAULT,
  parameter AW = 6
) (
  input wire clk_sys, // system clock
  input wire [AW-1:0] addr, // shared read/write address
  input wire wr_en, // write strobe, high active
  input wire [WIDTH-1:0] wr_data, // word to store
  output wire [WIDTH-1:0] rd_data // word at addr, one cycle later
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [WIDTH-1:0] rd_data_r;

  // no reset on the array: contents are only valid behind the pointers
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data_r <= mem[addr];
  end

  assign rd_data = rd_data_r;
endmodule // sfp_ram

// ### rtl/sfp_stage.v
// small staging buffer between the write port and the array
`timescale 1ns/1ns
`include "sfp_defs.vh"

module sfp_stage #(
  parameter WIDTH = `SFP_DATA_W,
  parameter DEPTH = `SFP_STAGE_DEPTH,
  parameter AW = 3
) (
  input wire clk_sys, // system clock
  input wire reset_n, // asynchronous reset, active low
  input wire in_valid, // push request
  output wire in_ready, // room for a push
  input wire [WIDTH-1:0] in_data, // word pushed
  output wire out_valid, // a word waits
  input wire out_ready, // drain accepts the word
  output wire [WIDTH-1:0] out_data // oldest word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire push;
  wire pop;
  wire [AW:0] used;

  // full and empty from the pointer distance, extra bit tells laps apart
  assign used = wr_ptr_r - rd_ptr_r;
  assign in_ready = (used != DEPTH[AW:0]);
  assign out_valid = (used != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_r[AW-1:0]];

  // words themselves need no reset
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // pointer updates
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sfp_stage

// ### rtl/sfp_fifo.v
// 9-bit fifo with programmable almost flags, pin clocks sampled by clk_sys
`timescale 1ns/1ns
`include "sfp_defs.vh"

// How it works
// (R1) nine-bit words in and out
// (R2) reset returns both pointers to zero
// (R3) outside logic resets before first write
// (R4) reset: full flags high, empty flags low
// (R5) reset clears output register, defaults offsets
// (R6) full flags change only on write edges
// (R7) empty flags change only on read edges
// (R8) clocks may be unrelated or identical
// (R9) load mode: low enable stores each edge
// (R10) enable high stores nothing, input held
// (R11) full refuses writes until a read frees
// (R12) both read enables low load output register
// (R13) either read enable high holds output
// (R14) empty refuses reads until a write lands
// (R15) output enable low drives bus, else released
// (R16) load pin strapped at reset picks mode
// (R17) dual enable mode: first low, second high
// (R18) four eight-bit offset registers, load mode access
// (R19) offset writes rotate empty lo/hi, full lo/hi
// (R20) leaving load keeps place in rotation
// (R21) offset reads follow same rotation
// (R22) never read and write offsets together
// (R23) empty when read pointer meets write pointer
// (R24) full when count reaches depth
// (R25) almost empty while count at most offset
// (R26) almost full while count reaches depth minus offset
// (R27) cross-port flag release may lag cycles
// (R28) depth parameter, widths follow it
module sfp_fifo #(
  parameter DEPTH = `SFP_DEPTH_DEFAULT, // array words: 64, 256, 512, 1024, 2048 or 4096
  parameter STAGE_DEPTH = `SFP_STAGE_DEPTH // words of write staging
) (
  input wire clk_sys, // system clock, 20 MHz
  input wire reset_n, // asynchronous reset, active low
  input wire write_clock, // write port clock pin
  input wire read_clock, // read port clock pin
  input wire [`SFP_DATA_W-1:0] write_data_bus, // write data pins
  input wire write_enable_a_n, // first write enable, active low
  input wire write_enable_b_or_load, // second enable or load, strapped
  input wire read_enable_a_n, // first read enable, active low
  input wire read_enable_b_n, // second read enable, active low
  input wire output_enable_n, // output enable, active low
  output wire [`SFP_DATA_W-1:0] read_data_bus, // output register
  output wire read_data_oe, // high while read_data_bus is driven
  output wire full_flag_n, // full, active low
  output wire empty_flag_n, // empty, active low
  output wire almost_full_flag_n, // almost full, active low
  output wire almost_empty_flag_n // almost empty, active low
);
  // integer log2 for power-of-two sizes
  function integer sfp_log2;
    input integer val;
    integer k;
    begin
      sfp_log2 = 0;
      for (k = 1; k < val; k = k * 2) begin
        sfp_log2 = sfp_log2 + 1;
      end
    end
  endfunction

  // address width; pointers carry one bit more to tell full from empty
  localparam AW = sfp_log2(DEPTH); // [R28]
  localparam SW = sfp_log2(STAGE_DEPTH);
  localparam [AW:0] DEPTH_CNT = {1'b1, {AW{1'b0}}};
  localparam [AW:0] ONE = {{AW{1'b0}}, 1'b1};

  // words between two pointers
  function [AW:0] sfp_fill;
    input [AW:0] head;
    input [AW:0] tail;
    begin
      sfp_fill = head - tail;
    end
  endfunction

  // offset value from a byte pair, cut to the address width
  function [AW:0] sfp_offset;
    input [`SFP_OFF_W-1:0] hi;
    input [`SFP_OFF_W-1:0] lo;
    reg [2*`SFP_OFF_W-1:0] both;
    begin
      both = {hi, lo};
      sfp_offset = {1'b0, both[AW-1:0]}; // [R28]
    end
  endfunction

  // pin synchronisers: stages one to three have no reset, they only carry pin levels; the level register resets to idle
  reg [`SFP_PINS_W-1:0] pin_s1_r;
  reg [`SFP_PINS_W-1:0] pin_s2_r;
  reg [`SFP_PINS_W-1:0] pin_s3_r;
  reg [`SFP_PINS_W-1:0] pin_lvl_r;
  wire [`SFP_PINS_W-1:0] pin_raw;
  wire [`SFP_PINS_W-1:0] pin_lvl_nxt;

  // strap capture
  reg rst_hold_r;
  reg load_mode_r;

  // pointers and flags
  reg [AW:0] wptr_r;
  reg [AW:0] rptr_r;
  reg [AW:0] ramw_r;
  reg full_flag_n_r;
  reg empty_flag_n_r;
  reg almost_full_flag_n_r;
  reg almost_empty_flag_n_r;

  // offset registers and their rotation
  reg [`SFP_OFF_W-1:0] empty_offset_low_r;
  reg [`SFP_OFF_W-1:0] empty_offset_high_r;
  reg [`SFP_OFF_W-1:0] full_offset_low_r;
  reg [`SFP_OFF_W-1:0] full_offset_high_r;
  reg [1:0] off_sel_r;
  reg [`SFP_OFF_W-1:0] off_sel_val;

  // read side
  reg [`SFP_DATA_W-1:0] out_r;
  reg rd_pend_r;

  wire wr_edge;
  wire rd_edge;
  wire load_active;
  wire wr_req;
  wire wr_go;
  wire off_wr;
  wire rd_both;
  wire off_rd;
  wire rd_go;
  wire stage_in_ready;
  wire stage_out_valid;
  wire stage_out_ready;
  wire [`SFP_DATA_W-1:0] stage_out_data;
  wire [`SFP_DATA_W-1:0] ram_rd_data;
  wire [AW-1:0] ram_addr;
  wire drain;
  wire [AW:0] wptr_nxt;
  wire [AW:0] rptr_nxt;
  wire [AW:0] wr_fill;
  wire [AW:0] rd_fill;
  wire [AW:0] empty_off;
  wire [AW:0] full_off;

  // all sampled pins in one vector, the two port clocks in the top bits
  assign pin_raw = {write_clock, read_clock, write_enable_a_n, write_enable_b_or_load,
                    read_enable_a_n, read_enable_b_n, output_enable_n, write_data_bus};

  // three-stage chain; s1 feeds s2 only
  always @(posedge clk_sys) begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
  end

  // a level change counts once stages two and three agree
  assign pin_lvl_nxt = (~(pin_s2_r ^ pin_s3_r) & pin_s3_r) | ((pin_s2_r ^ pin_s3_r) & pin_lvl_r);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_lvl_r <= `SFP_PIN_IDLE;
    end else begin
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  // rising edges of the port clocks; both may be one clock or unrelated [R8]
  // first cycle after reset is masked: the level register still holds its idle value,
  // so a pin clock high at release would look like a rise; a real rise there is lost
  assign wr_edge = ~rst_hold_r & ~pin_lvl_r[`SFP_PIN_WCLK] & pin_lvl_nxt[`SFP_PIN_WCLK];
  assign rd_edge = ~rst_hold_r & ~pin_lvl_r[`SFP_PIN_RCLK] & pin_lvl_nxt[`SFP_PIN_RCLK];

  // strap: hold flag leaves reset at 1 so the first edge after release catches the pin
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_hold_r <= 1'b1;
    end else begin
      rst_hold_r <= 1'b0;
    end
  end

  // pin high selects second write enable, low selects load mode
  always @(posedge clk_sys) begin
    if (rst_hold_r) begin
      load_mode_r <= ~pin_s3_r[`SFP_PIN_WEN_B]; // [R16]
    end
  end

  // controls are taken from the level one cycle before the clock edge shows
  assign load_active = load_mode_r & ~pin_lvl_r[`SFP_PIN_WEN_B];
  assign wr_req = load_mode_r ? ~pin_lvl_r[`SFP_PIN_WEN_A] : // [R9] [R10]
                  (~pin_lvl_r[`SFP_PIN_WEN_A] & pin_lvl_r[`SFP_PIN_WEN_B]); // [R17]
  // full flag and a full staging buffer both refuse the word
  assign wr_go = wr_edge & ~load_active & wr_req & full_flag_n_r & stage_in_ready; // [R11]
  assign off_wr = wr_edge & load_active & ~pin_lvl_r[`SFP_PIN_WEN_A]; // [R19]
  assign rd_both = ~pin_lvl_r[`SFP_PIN_REN_A] & ~pin_lvl_r[`SFP_PIN_REN_B];
  // an offset write in the same cycle wins; reading then is a misuse anyway
  assign off_rd = rd_edge & load_active & rd_both & ~off_wr; // [R21] [R22]
  assign rd_go = rd_edge & ~load_active & rd_both & empty_flag_n_r; // [R12] [R13] [R14]

  // write staging buffer
  sfp_stage #(
    .WIDTH(`SFP_DATA_W),
    .DEPTH(STAGE_DEPTH),
    .AW(SW)
  ) u_stage (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(wr_go),
    .in_ready(stage_in_ready),
    .in_data(pin_lvl_r[`SFP_PIN_DATA_HI:`SFP_PIN_DATA_LO]), // [R1]
    .out_valid(stage_out_valid),
    .out_ready(stage_out_ready),
    .out_data(stage_out_data)
  );

  // one-port array: a read owns the port, so the drain stalls that cycle
  assign stage_out_ready = ~rd_go;
  assign drain = stage_out_valid & stage_out_ready;
  assign ram_addr = rd_go ? rptr_r[AW-1:0] : ramw_r[AW-1:0];

  // single-port storage array behind the staging buffer
  sfp_ram #(
    .WIDTH(`SFP_DATA_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_ram (
    .clk_sys(clk_sys),
    .addr(ram_addr),
    .wr_en(drain),
    .wr_data(stage_out_data),
    .rd_data(ram_rd_data)
  );

  // pointer steps and the offsets as counts of words
  assign wptr_nxt = wr_go ? wptr_r + ONE : wptr_r;
  assign rptr_nxt = rd_go ? rptr_r + ONE : rptr_r;
  assign empty_off = sfp_offset(empty_offset_high_r, empty_offset_low_r);
  assign full_off = sfp_offset(full_offset_high_r, full_offset_low_r);
  // write side counts staged words too, so full is honest
  assign wr_fill = sfp_fill(wptr_nxt, rptr_r);
  // read side counts only words already in the array
  assign rd_fill = sfp_fill(ramw_r, rptr_nxt);

  // pointers; another port's change reaches a flag at this port's next edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wptr_r <= {(AW+1){1'b0}}; // [R2]
      rptr_r <= {(AW+1){1'b0}}; // [R2]
      ramw_r <= {(AW+1){1'b0}};
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      if (drain) begin
        ramw_r <= ramw_r + ONE;
      end
    end
  end

  // write-port flags move only on write clock edges
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      full_flag_n_r <= `SFP_FLAG_HIGH; // [R4]
      almost_full_flag_n_r <= `SFP_FLAG_HIGH; // [R4]
    end else if (wr_edge) begin // [R6] [R27]
      full_flag_n_r <= (wr_fill != DEPTH_CNT); // [R24] [R11]
      almost_full_flag_n_r <= ~(wr_fill >= DEPTH_CNT - full_off); // [R26]
    end
  end

  // read-port flags move only on read clock edges
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      empty_flag_n_r <= `SFP_FLAG_LOW; // [R4]
      almost_empty_flag_n_r <= `SFP_FLAG_LOW; // [R4]
    end else if (rd_edge) begin // [R7] [R27]
      empty_flag_n_r <= (rd_fill != {(AW+1){1'b0}}); // [R23] [R14]
      almost_empty_flag_n_r <= ~(rd_fill <= empty_off); // [R25]
    end
  end

  // offset register picked by the rotation
  always @* begin
    case (off_sel_r)
      `SFP_SEL_EMPTY_LO: off_sel_val = empty_offset_low_r;
      `SFP_SEL_EMPTY_HI: off_sel_val = empty_offset_high_r;
      `SFP_SEL_FULL_LO: off_sel_val = full_offset_low_r;
      `SFP_SEL_FULL_HI: off_sel_val = full_offset_high_r;
      default: off_sel_val = empty_offset_low_r;
    endcase
  end

  // offset registers; the rotation survives leaving load mode
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      empty_offset_low_r <= `SFP_OFF_DEFAULT_LO; // [R5]
      empty_offset_high_r <= `SFP_OFF_DEFAULT_HI; // [R5]
      full_offset_low_r <= `SFP_OFF_DEFAULT_LO; // [R5]
      full_offset_high_r <= `SFP_OFF_DEFAULT_HI; // [R5]
      off_sel_r <= `SFP_SEL_RESET;
    end else begin
      if (off_wr) begin // [R18]
        case (off_sel_r)
          `SFP_SEL_EMPTY_LO: empty_offset_low_r <= pin_lvl_r[`SFP_OFF_W-1:0];
          `SFP_SEL_EMPTY_HI: empty_offset_high_r <= pin_lvl_r[`SFP_OFF_W-1:0];
          `SFP_SEL_FULL_LO: full_offset_low_r <= pin_lvl_r[`SFP_OFF_W-1:0];
          `SFP_SEL_FULL_HI: full_offset_high_r <= pin_lvl_r[`SFP_OFF_W-1:0];
          default: empty_offset_low_r <= empty_offset_low_r;
        endcase
      end
      // one rotation shared by reads and writes
      if (off_wr | off_rd) begin
        off_sel_r <= off_sel_r + 2'h1; // [R19] [R20] [R21]
      end
    end
  end

  // output register: array word lands a cycle after the read, offsets at once
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_r <= `SFP_OUT_RESET; // [R5]
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_go;
      if (rd_pend_r) begin
        out_r <= ram_rd_data; // [R12]
      end else if (off_rd) begin
        out_r <= {1'b0, off_sel_val}; // [R18]
      end
    end
  end

  // bus driven only while output enable is low
  assign read_data_bus = out_r;
  assign read_data_oe = ~pin_lvl_r[`SFP_PIN_OE]; // [R15]
  assign full_flag_n = full_flag_n_r;
  assign empty_flag_n = empty_flag_n_r;
  assign almost_full_flag_n = almost_full_flag_n_r;
  assign almost_empty_flag_n = almost_empty_flag_n_r;
endmodule // sfp_fifo

// ### sim/sfp_monitor.sv
// port assertions for the 9-bit fifo
`timescale 1ns/1ns
`include "sfp_defs.vh"
module sfp_monitor (
  input wire clk_sys, // system clock
  input wire reset_n, // reset, active low
  input wire write_clock, // write pin clock
  input wire read_clock, // read pin clock
  input wire output_enable_n, // output enable pin
  input wire [`SFP_DATA_W-1:0] read_data_bus, // output register
  input wire read_data_oe, // bus driven
  input wire full_flag_n, // full
  input wire empty_flag_n, // empty
  input wire almost_full_flag_n, // almost full
  input wire almost_empty_flag_n // almost empty
);
  reg [3:0] wa_r;
  reg [3:0] ra_r;
  wire [3:0] flg = {full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n};
  // cycles since a pin clock rise; saturates so an idle port never looks fresh
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wa_r <= 4'hf;
      ra_r <= 4'hf;
    end else begin
      wa_r <= $rose(write_clock) ? 4'h0 : (wa_r == 4'hf ? wa_r : wa_r + 4'h1);
      ra_r <= $rose(read_clock) ? 4'h0 : (ra_r == 4'hf ? ra_r : ra_r + 4'h1);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  rst_flags_a: assert property (disable iff (1'h0) !reset_n [*2] |-> flg == 4'hc)
    else $error("flags wrong in reset");
  rst_out_a: assert property (disable iff (1'h0) !reset_n [*2] |-> read_data_bus == 9'h000)
    else $error("output register not cleared in reset");
  full_wclk_a: assert property ($changed(full_flag_n) |-> wa_r inside {[2:5]})
    else $error("full moved away from a write edge");
  afull_wclk_a: assert property ($changed(almost_full_flag_n) |-> wa_r inside {[2:5]})
    else $error("almost full moved away from a write edge");
  empty_rclk_a: assert property ($changed(empty_flag_n) |-> ra_r inside {[2:5]})
    else $error("empty moved away from a read edge");
  aempty_rclk_a: assert property ($changed(almost_empty_flag_n) |-> ra_r inside {[2:5]})
    else $error("almost empty moved away from a read edge");
  out_hold_a: assert property ($changed(read_data_bus) |-> ra_r inside {[2:6]})
    else $error("output changed without a read edge");
  full_afull_a: assert property (!full_flag_n |-> !almost_full_flag_n)
    else $error("full without almost full");
  empty_aempty_a: assert property (!empty_flag_n |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
  oe_on_a: assert property ($fell(output_enable_n) |-> ##[2:6] read_data_oe)
    else $error("bus not driven after enable");
  cover property ($fell(full_flag_n));
  cover property ($rose(almost_empty_flag_n));
  cover property ($fell(output_enable_n));
endmodule // sfp_monitor

bind sfp_fifo sfp_monitor mon (.clk_sys(clk_sys), .reset_n(reset_n),
  .write_clock(write_clock), .read_clock(read_clock), .output_enable_n(output_enable_n),
  .read_data_bus(read_data_bus), .read_data_oe(read_data_oe), .full_flag_n(full_flag_n),
  .empty_flag_n(empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
  .almost_empty_flag_n(almost_empty_flag_n));

// ### sim/sfp_pin_partner.sv
// producer and consumer on the pin-clocked ports
`timescale 1ns/1ns
`include "sfp_defs.vh"
module sfp_pin_partner (
  output reg write_clock = 1'h0, // write pin clock
  output reg read_clock = 1'h0, // read pin clock
  output reg [`SFP_DATA_W-1:0] write_data_bus = 9'h000, // word offered
  output reg write_enable_a_n = 1'h1, // write enable, active low
  output reg read_enable_a_n = 1'h1, // read enable, active low
  output reg read_enable_b_n = 1'h1 // second read enable, active low
);
  // free-running 400 ns pin clocks, phases unrelated
  initial begin
    #73;
    forever #200 read_clock = ~read_clock;
  end
  always #200 write_clock = ~write_clock;
  // move at the fall, clear of the rise; idle data inverted, not left stale
  task wr(input en_n, input [`SFP_DATA_W-1:0] d);
    begin
      @(negedge write_clock);
      #1;
      write_enable_a_n = en_n;
      write_data_bus = en_n ? ~write_data_bus : d;
    end
  endtask
  task rd(input a_n, input b_n);
    begin
      @(negedge read_clock);
      #1;
      read_enable_a_n = a_n;
      read_enable_b_n = b_n;
    end
  endtask
endmodule // sfp_pin_partner

// ### sim/sfp_fifo_test.sv
// self-checking bench for the 9-bit fifo
`timescale 1ns/1ns
`include "sfp_defs.vh"
module sfp_fifo_test;
  reg clk_sys = 1'h0;
  reg reset_n = 1'h0;
  reg output_enable_n = 1'h1;
  reg load_b = 1'h0;
  wire write_clock, read_clock, wa_n, ra_n, rb_n, oe, ff, ef, af, ae;
  wire [8:0] wd;
  wire [8:0] q;
  wire [3:0] flg = {ff, af, ae, ef};
  integer err_count = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer i;
  always #25 clk_sys = ~clk_sys;
  sfp_pin_partner far (.write_clock(write_clock), .read_clock(read_clock),
    .write_data_bus(wd), .write_enable_a_n(wa_n), .read_enable_a_n(ra_n),
    .read_enable_b_n(rb_n));
  sfp_fifo #(.DEPTH(64), .STAGE_DEPTH(8)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .write_clock(write_clock), .read_clock(read_clock), .write_data_bus(wd),
    .write_enable_a_n(wa_n), .write_enable_b_or_load(load_b), .read_enable_a_n(ra_n),
    .read_enable_b_n(rb_n), .output_enable_n(output_enable_n), .read_data_bus(q),
    .read_data_oe(oe), .full_flag_n(ff), .empty_flag_n(ef), .almost_full_flag_n(af),
    .almost_empty_flag_n(ae));
  // hang guard: far above the few thousand cycles the run needs
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [8:0] got, input [8:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #2;
    end
  endtask
  task put(input integer n, input [8:0] base);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
        far.wr(1'h0, base + k[8:0]);
      far.wr(1'h1, 9'h000);
      idle(24);
    end
  endtask
  task get(input [8:0] exp);
    begin
      far.rd(1'h0, 1'h0);
      far.rd(1'h1, 1'h1);
      idle(16);
      chk(q, exp);
    end
  endtask
  task do_reset(input strap);
    begin
      reset_n = 1'h0;
      load_b = strap;
      idle(5);
      reset_n = 1'h1;
      idle(2);
      load_b = 1'h1;
      idle(8);
      chk({5'h00, flg}, 9'h00c);
      chk(q, 9'h000);
    end
  endtask
  task t_order;
    begin
      put(3, 9'h1fd);
      chk({5'h00, flg}, 9'h00d);
      get(9'h1fd);
      get(9'h1fe);
      get(9'h1ff);
      chk({5'h00, flg}, 9'h00c);
      get(9'h1ff);
      $display("order test done");
    end
  endtask
  task t_hold;
    begin
      far.wr(1'h1, 9'h000);
      idle(24);
      chk({5'h00, flg}, 9'h00c);
      put(1, 9'h0aa);
      far.rd(1'h1, 1'h0);
      far.rd(1'h0, 1'h1);
      far.rd(1'h1, 1'h1);
      idle(16);
      chk(q, 9'h1ff);
      get(9'h0aa);
      output_enable_n = 1'h0;
      idle(8);
      chk({8'h00, oe}, 9'h001);
      output_enable_n = 1'h1;
      idle(8);
      chk({8'h00, oe}, 9'h000);
      $display("hold test done");
    end
  endtask
  task t_full;
    begin
      put(56, 9'h000);
      chk({5'h00, flg}, 9'h00f);
      put(8, 9'h038);
      chk({5'h00, flg}, 9'h003);
      put(1, 9'h1aa);
      get(9'h000);
      chk({5'h00, flg}, 9'h00b);
      put(1, 9'h1bb);
      for (i = 1; i < 64; i = i + 1)
        get(i[8:0]);
      get(9'h1bb);
      $display("full test done");
    end
  endtask
  task t_offset;
    begin
      load_b = 1'h0;
      idle(8);
      get(9'h007);
      get(9'h000);
      get(9'h007);
      get(9'h000);
      far.wr(1'h0, 9'h002);
      far.wr(1'h0, 9'h000);
      far.wr(1'h1, 9'h000);
      idle(2);
      load_b = 1'h1;
      idle(8);
      load_b = 1'h0;
      idle(8);
      far.wr(1'h0, 9'h103);
      far.wr(1'h0, 9'h000);
      far.wr(1'h1, 9'h000);
      idle(8);
      get(9'h002);
      get(9'h000);
      get(9'h003);
      get(9'h000);
      load_b = 1'h1;
      idle(8);
      put(2, 9'h050);
      chk({5'h00, flg}, 9'h00d);
      put(1, 9'h052);
      chk({5'h00, flg}, 9'h00f);
      get(9'h050);
      $display("offset test done");
    end
  endtask
  task t_dual;
    begin
      put(2, 9'h0c0);
      do_reset(1'h1);
      load_b = 1'h0;
      put(1, 9'h033);
      chk({5'h00, flg}, 9'h00c);
      load_b = 1'h1;
      put(1, 9'h044);
      get(9'h044);
      $display("dual enable test done");
    end
  endtask
  initial begin
    do_reset(1'h0);
    t_order;
    t_hold;
    t_full;
    t_offset;
    t_dual;
    tally_and_finish;
  end
endmodule // sfp_fifo_test
